// >>> verilog/tsmu_unit.sv
`timescale 1ns/1ns
module tsmu_unit (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link to the sequencer.
    tsmu_link_if.dev         link,
    // Data memory port.
    output logic             mem_rd,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata
);

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_CHECK = 4'b0001,
        S_WAIT  = 4'b0010,
        S_CMP   = 4'b0011,
        S_TSEL  = 4'b0100,
        S_TWAIT = 4'b0101,
        S_TDATA = 4'b0110,
        S_TMOV  = 4'b0111,
        S_TPTR  = 4'b1000,
        S_FIN   = 4'b1001
    } tsmu_state_e;

    tsmu_state_e        state;
    tsmu_pkg::tsmu_op_e op_q;
    logic [15:0]        base;
    logic [15:0]        idx;
    logic [7:0]         len;
    logic [15:0]        ptr_q;
    logic [15:0]        result;
    logic               err;
    logic               is_search;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding.
    ////////////////////////////////////////////////////////////////////////////////

    wire logic [15:0] sel;
    wire logic [15:0] next_ptr;
    wire logic        at_limit;
    wire logic        out_range;
    wire logic        idx_out;
    wire logic        hit;
    wire logic        is_ttd;

    tsmu_ptr_step u_step (
        .ptr       (ptr_q),
        .len       (len),
        .sel       (sel),
        .next_ptr  (next_ptr),
        .at_limit  (at_limit),
        .out_range (out_range)
    );

    assign is_ttd  = (op_q == tsmu_pkg::TSMU_OP_TTD);
    assign idx_out = (idx >= {8'h00, len});
    assign hit     = (op_q == tsmu_pkg::TSMU_OP_FIND) ? (mem_rdata == link.operand)
                                                      : (mem_rdata > link.operand);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing.
    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            op_q  <= tsmu_pkg::TSMU_OP_FIND;
            base  <= tsmu_pkg::RST_WORD;
            idx   <= tsmu_pkg::RST_WORD;
            len   <= 8'h00;
            ptr_q <= tsmu_pkg::RST_WORD;
            result <= tsmu_pkg::RST_WORD;
            err   <= 1'b0;
            is_search <= 1'b0;
            mem_rd <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= tsmu_pkg::RST_WORD;
            mem_wdata <= tsmu_pkg::RST_WORD;
            link.busy <= 1'b0;
            link.done <= 1'b0;
            link.acc_we <= 1'b0;
            link.acc_out <= tsmu_pkg::RST_ACC;
        end else begin
            mem_rd <= 1'b0;
            mem_we <= 1'b0;
            link.done <= 1'b0;
            link.acc_we <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (link.start) begin
                        link.busy <= 1'b1;
                        op_q <= link.op;
                        state <= S_CHECK;
                        is_search <= (link.op != tsmu_pkg::TSMU_OP_TTD);
                        if (link.op == tsmu_pkg::TSMU_OP_FIND) begin
                            len  <= link.stack2[7:0];
                            base <= link.stack1;
                            idx  <= link.acc_in[15:0];
                        end else begin
                            len  <= link.stack1[7:0];
                            base <= link.acc_in[15:0];
                            idx  <= tsmu_pkg::RST_WORD;
                        end
                    end
                end
                S_CHECK: begin
                    if (is_ttd) begin
                        mem_rd <= 1'b1;
                        mem_addr <= base;
                        state <= S_WAIT;
                    end else if (idx_out) begin
                        err <= 1'b1;
                        result <= tsmu_pkg::RST_WORD;
                        state <= S_FIN;
                    end else begin
                        mem_rd <= 1'b1;
                        mem_addr <= base + idx;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    state <= S_CMP;
                end
                S_CMP: begin
                    if (is_ttd) begin
                        ptr_q <= mem_rdata;
                        state <= S_TSEL;
                    end else if (hit) begin
                        err <= 1'b0;
                        result <= idx;
                        state <= S_FIN;
                    end else begin
                        idx <= idx + 16'h0001;
                        state <= S_CHECK;
                    end
                end
                S_TSEL: begin
                    if (out_range) begin
                        state <= S_FIN;
                    end else begin
                        mem_rd <= 1'b1;
                        mem_addr <= base + sel;
                        state <= S_TWAIT;
                    end
                end
                S_TWAIT: begin
                    state <= S_TDATA;
                end
                S_TDATA: begin
                    mem_we <= 1'b1;
                    mem_addr <= link.operand;
                    mem_wdata <= mem_rdata;
                    state <= S_TMOV;
                end
                S_TMOV: begin
                    mem_we <= 1'b1;
                    mem_addr <= base;
                    mem_wdata <= next_ptr;
                    state <= S_TPTR;
                end
                S_TPTR: begin
                    state <= S_FIN;
                end
                S_FIN: begin
                    link.busy <= 1'b0;
                    link.done <= 1'b1;
                    link.acc_we <= is_search;
                    link.acc_out <= {16'h0000, result};
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags.
    ////////////////////////////////////////////////////////////////////////////////

    wire logic fin_search;
    wire logic ptr_update;

    assign fin_search = (state == S_FIN) && is_search;
    assign ptr_update = (state == S_TMOV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.table_error_flag <= 1'b0;
        end else if (fin_search) begin
            link.table_error_flag <= err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.pointer_limit_flag <= 1'b0;
        end else if (ptr_update) begin
            link.pointer_limit_flag <= at_limit;
        end else if (link.scan_end) begin
            link.pointer_limit_flag <= 1'b0;
        end
    end

endmodule : tsmu_unit

// >>> verilog/tsmu_pkg.sv
// Functional notes
// - Equal search scans up to 255 words.
// - Sequencer puts length in stack level two.
// - Sequencer puts start in level one, offset in accumulator.
// - Equal hit returns its offset in accumulator.
// - Bad offset or miss sets error; miss returns zero.
// - Search offset is accumulator low sixteen bits.
// - Error flag holds until next search; limit flag until next move or scan end.
// - Greater search finds first word above operand.
// - Greater search: length level one, start accumulator.
// - Greater miss returns zero and sets error.
// - Move copies selected word, then pointer plus one.
// - Table start word is the pointer, data follows.
// - Move runs once per scan while enabled.
// - Pointer counts to length, then wraps to one.
// - Pointer zero and one both pick first word.
// - Limit flag at pointer equals length, until scan end.
// - Sequencer puts move length level one, start accumulator.
// - Program should one-shot the enable for single runs.
// - Program preloads the pointer word only once.
// - All table words are sixteen bits.
package tsmu_pkg;

    localparam int WORD_W = 16;
    localparam int ACC_W  = 32;
    localparam int LEN_W  = 8;

    typedef enum logic [1:0] {
        TSMU_OP_FIND = 2'b00,
        TSMU_OP_GRT  = 2'b01,
        TSMU_OP_TTD  = 2'b10
    } tsmu_op_e;

    // Register offsets of the sequencer end.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_STACK1  = 8'h08;
    localparam logic [7:0] OFS_STACK2  = 8'h0c;
    localparam logic [7:0] OFS_ACC     = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    // Control register fields.
    localparam int CTRL_START    = 0;
    localparam int CTRL_OP_LO    = 1;
    localparam int CTRL_TTD_EN   = 3;
    localparam int CTRL_SCAN_END = 4;

    // Status register fields.
    localparam int STAT_BUSY  = 0;
    localparam int STAT_TERR  = 1;
    localparam int STAT_PLIM  = 2;
    localparam int STAT_DONE  = 3;

    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_ACC  = 32'h0000_0000;

endpackage : tsmu_pkg

// >>> verilog/tsmu_link_if.sv
`timescale 1ns/1ns
interface tsmu_link_if;
    logic                           start;
    tsmu_pkg::tsmu_op_e             op;
    logic [tsmu_pkg::WORD_W-1:0]    operand;
    logic [tsmu_pkg::WORD_W-1:0]    stack1;
    logic [tsmu_pkg::WORD_W-1:0]    stack2;
    logic [tsmu_pkg::ACC_W-1:0]     acc_in;
    logic                           scan_end;
    logic                           busy;
    logic                           done;
    logic                           acc_we;
    logic [tsmu_pkg::ACC_W-1:0]     acc_out;
    logic                           table_error_flag;
    logic                           pointer_limit_flag;

    modport dev (
        input  start, op, operand, stack1, stack2, acc_in, scan_end,
        output busy, done, acc_we, acc_out, table_error_flag, pointer_limit_flag
    );
    modport seq (
        output start, op, operand, stack1, stack2, acc_in, scan_end,
        input  busy, done, acc_we, acc_out, table_error_flag, pointer_limit_flag
    );
endinterface : tsmu_link_if

// >>> verilog/tsmu_ptr_step.sv
`timescale 1ns/1ns
module tsmu_ptr_step (
    // Pointer and table length.
    input  wire logic [15:0] ptr,
    input  wire logic [7:0]  len,
    // Derived selection and next pointer.
    output wire logic [15:0] sel,
    output wire logic [15:0] next_ptr,
    output wire logic        at_limit,
    output wire logic        out_range
);
    wire logic [15:0] len_w;

    assign len_w     = {8'h00, len};
    assign sel       = (ptr == 16'h0000) ? 16'h0001 : ptr;
    assign out_range = (len == 8'h00) || (ptr > len_w);
    assign next_ptr  = (ptr == len_w) ? 16'h0001 : ptr + 16'h0001;
    assign at_limit  = (next_ptr == len_w);
endmodule : tsmu_ptr_step

// >>> verilog/tsmu_seq.sv
`timescale 1ns/1ns
module tsmu_seq (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the unit.
    tsmu_link_if.seq         link
);

    logic [1:0]  op_reg;
    logic        ttd_en;
    logic        done_seen;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding.
    ////////////////////////////////////////////////////////////////////////////////

    wire logic        access;
    wire logic        wr_fire;
    wire logic        hit;
    wire logic        idle;
    wire logic        wr_ctrl;
    wire logic        go_cmd;
    wire logic        go_scan;
    wire logic [31:0] rd_mux;
    wire logic [31:0] status;

    assign access  = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite;
    assign idle    = !link.busy && !link.start;
    assign wr_ctrl = wr_fire && (paddr == tsmu_pkg::OFS_CTRL);
    assign go_cmd  = wr_ctrl && pwdata[tsmu_pkg::CTRL_START] && idle;
    assign go_scan = wr_ctrl && pwdata[tsmu_pkg::CTRL_SCAN_END] && ttd_en && idle;
    assign hit     = (paddr == tsmu_pkg::OFS_CTRL) || (paddr == tsmu_pkg::OFS_OPERAND)
                   || (paddr == tsmu_pkg::OFS_STACK1) || (paddr == tsmu_pkg::OFS_STACK2)
                   || (paddr == tsmu_pkg::OFS_ACC) || (paddr == tsmu_pkg::OFS_STATUS);
    assign status  = {28'h0000000, done_seen, link.pointer_limit_flag,
                      link.table_error_flag, link.busy};
    assign rd_mux  = (paddr == tsmu_pkg::OFS_CTRL)    ? {28'h0000000, ttd_en, op_reg, 1'b0} :
                     (paddr == tsmu_pkg::OFS_OPERAND) ? {16'h0000, link.operand} :
                     (paddr == tsmu_pkg::OFS_STACK1)  ? {16'h0000, link.stack1} :
                     (paddr == tsmu_pkg::OFS_STACK2)  ? {16'h0000, link.stack2} :
                     (paddr == tsmu_pkg::OFS_ACC)     ? link.acc_in :
                     (paddr == tsmu_pkg::OFS_STATUS)  ? status : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer.
    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !hit;
            prdata  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and link drive.
    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= 2'b00;
            ttd_en <= 1'b0;
            done_seen <= 1'b0;
            link.start <= 1'b0;
            link.scan_end <= 1'b0;
            link.op <= tsmu_pkg::TSMU_OP_FIND;
            link.operand <= tsmu_pkg::RST_WORD;
            link.stack1 <= tsmu_pkg::RST_WORD;
            link.stack2 <= tsmu_pkg::RST_WORD;
            link.acc_in <= tsmu_pkg::RST_ACC;
        end else begin
            link.start <= go_cmd || go_scan;
            link.scan_end <= wr_ctrl && pwdata[tsmu_pkg::CTRL_SCAN_END];
            if (wr_ctrl) begin
                op_reg <= pwdata[tsmu_pkg::CTRL_OP_LO +: 2];
                ttd_en <= pwdata[tsmu_pkg::CTRL_TTD_EN];
            end
            if (go_cmd) begin
                link.op <= tsmu_pkg::tsmu_op_e'(pwdata[tsmu_pkg::CTRL_OP_LO +: 2]);
            end else if (go_scan) begin
                link.op <= tsmu_pkg::TSMU_OP_TTD;
            end
            if (link.done) begin
                done_seen <= 1'b1;
            end else if (go_cmd || go_scan) begin
                done_seen <= 1'b0;
            end
            if (wr_fire && idle) begin
                if (paddr == tsmu_pkg::OFS_OPERAND) begin
                    link.operand <= pwdata[15:0];
                end
                if (paddr == tsmu_pkg::OFS_STACK1) begin
                    link.stack1 <= pwdata[15:0];
                end
                if (paddr == tsmu_pkg::OFS_STACK2) begin
                    link.stack2 <= pwdata[15:0];
                end
            end
            if (link.acc_we) begin
                link.acc_in <= link.acc_out;
            end else if (wr_fire && idle && (paddr == tsmu_pkg::OFS_ACC)) begin
                link.acc_in <= pwdata;
            end
        end
    end

endmodule : tsmu_seq

// >>> tb/tsmu_props.sv
`timescale 1ns/1ns
module tsmu_props (
    // Clock and reset.
    input wire logic                       pclk,
    input wire logic                       presetn,
    // Link requests.
    input wire logic                       start,
    input wire tsmu_pkg::tsmu_op_e         op,
    input wire logic                       scan_end,
    // Link answers.
    input wire logic                       busy,
    input wire logic                       done,
    input wire logic                       acc_we,
    input wire logic [tsmu_pkg::ACC_W-1:0] acc_out,
    input wire logic                       table_error_flag,
    input wire logic                       pointer_limit_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    sequence launch_s;
        start && !busy;
    endsequence
    sequence search_end_s;
        done && op != tsmu_pkg::TSMU_OP_TTD;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    done_pulse_a: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    start_busy_a: assert property (launch_s |=> busy)
        else $error("busy not raised after start");
    busy_end_a: assert property ($fell(busy) |-> done)
        else $error("busy fell without done");
    search_bound_a: assert property (launch_s ##0 (op != tsmu_pkg::TSMU_OP_TTD) |-> ##[3:800] done)
        else $error("search did not finish in time");
    move_time_a: assert property (launch_s ##0 (op == tsmu_pkg::TSMU_OP_TTD) |-> ((##6 done) or (##10 done)))
        else $error("move did not finish in time");
    acc_result_a: assert property (search_end_s |-> acc_we)
        else $error("search result not written with done");
    miss_zero_a: assert property (search_end_s ##0 table_error_flag |-> acc_out == '0)
        else $error("failed search returned nonzero");
    err_hold_a: assert property ($changed(table_error_flag) |-> search_end_s)
        else $error("error flag changed outside search end");
    limit_cause_a: assert property ($rose(pointer_limit_flag) |-> busy && op == tsmu_pkg::TSMU_OP_TTD)
        else $error("limit flag rose outside a move");
    limit_clear_a: assert property (scan_end && !busy |=> !pointer_limit_flag)
        else $error("limit flag survived scan end");
endmodule : tsmu_props

// >>> tb/table_search_and_move_unit_tb.sv
`timescale 1ns/1ns
module table_search_and_move_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        mem_rd, mem_we, g, last_err, last_lim;
    logic [7:0]  paddr, l;
    logic [31:0] pwdata, prdata, rd, stat;
    logic [31:0] seed = 32'hf15a3b8d;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, b, k, val;
    logic [15:0] mem [0:2047];
    int          bad_count, samples_checked, cycles;

    tsmu_link_if link_if ();
    tsmu_seq u_tsmu_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
    tsmu_unit u_tsmu_unit (.pclk(pclk), .presetn(presetn), .link(link_if), .mem_rd(mem_rd), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    tsmu_props u_props (.pclk(pclk), .presetn(presetn), .start(link_if.start), .op(link_if.op),
        .scan_end(link_if.scan_end), .busy(link_if.busy), .done(link_if.done), .acc_we(link_if.acc_we),
        .acc_out(link_if.acc_out), .table_error_flag(link_if.table_error_flag),
        .pointer_limit_flag(link_if.pointer_limit_flag));

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory: read data is valid for one cycle, then scrambled.
    always @(posedge pclk) begin
        if (mem_we) mem[mem_addr[10:0]] <= mem_wdata;
        mem_rdata <= mem_rd ? mem[mem_addr[10:0]] : ~mem_rdata;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_f(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask : chk_f

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic run_op(input logic [31:0] ctrl, input logic [15:0] s1, input logic [15:0] s2,
                          input logic [15:0] opnd, input logic [31:0] acc, input logic jam);
        int n;
        apb(1'b1, tsmu_pkg::OFS_STACK1, {16'h0, s1});
        apb(1'b1, tsmu_pkg::OFS_STACK2, {16'h0, s2});
        apb(1'b1, tsmu_pkg::OFS_OPERAND, {16'h0, opnd});
        apb(1'b1, tsmu_pkg::OFS_ACC, acc);
        apb(1'b1, tsmu_pkg::OFS_CTRL, ctrl);
        if (jam) apb(1'b1, tsmu_pkg::OFS_ACC, 32'hdead_beef);
        n = 0;
        do begin
            apb(1'b0, tsmu_pkg::OFS_STATUS, 32'h0);
            n++;
        end while ((rd[0] !== 1'b0 || rd[3] !== 1'b1) && n < 400);
        stat = rd;
        chk_f(stat[tsmu_pkg::STAT_BUSY], 1'b0);
        chk_f(stat[tsmu_pkg::STAT_DONE], 1'b1);
        apb(1'b0, tsmu_pkg::OFS_ACC, 32'h0);
    endtask : run_op

    function automatic logic [32:0] exp_search(input logic grt, input logic [15:0] base, input logic [7:0] len,
                                               input logic [15:0] off, input logic [15:0] v);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        for (int i = grt ? 0 : off; i < len; i++)
            if (r[32] && (grt ? mem[base + i] > v : mem[base + i] == v))
                r = {1'b0, 32'(i)};
        return r;
    endfunction : exp_search

    task automatic search(input logic grt, input logic [15:0] base, input logic [7:0] len,
                          input logic [31:0] acc, input logic [15:0] v, input logic jam);
        logic [32:0] e;
        e = exp_search(grt, base, len, acc[15:0], v);
        if (grt) run_op(32'h3, {8'h0, len}, 16'h0, v, {16'h0, base}, jam);
        else run_op(32'h1, base, {8'h0, len}, v, acc, jam);
        chk_w(rd, e[31:0]);
        chk_f(stat[tsmu_pkg::STAT_TERR], e[32]);
        last_err = e[32];
    endtask : search

    task automatic move(input logic scan);
        logic [15:0] p, np, v;
        logic        lim;
        p = mem[16'h600];
        v = mem[16'h700];
        np = p;
        lim = last_lim;
        if (p <= 16'h3) begin
            v = mem[16'h600 + (p == 16'h0 ? 16'h1 : p)];
            np = (p == 16'h3) ? 16'h1 : p + 16'h1;
            lim = (np == 16'h3);
        end
        if (scan) apb(1'b1, tsmu_pkg::OFS_CTRL, 32'h0c);
        run_op(scan ? 32'h1c : 32'h05, 16'h3, 16'h0, 16'h700, 32'h600, 1'b0);
        chk_w({16'h0, mem[16'h700]}, {16'h0, v});
        chk_w({16'h0, mem[16'h600]}, {16'h0, np});
        chk_f(stat[tsmu_pkg::STAT_PLIM], lim);
        chk_f(stat[tsmu_pkg::STAT_TERR], last_err);
        last_lim = lim;
    endtask : move

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mem_rdata} = '0;
        {bad_count, samples_checked, cycles, last_err, last_lim} = '0;
        for (int i = 0; i < 2048; i++) mem[i] = 16'($random(seed));
        for (int i = 0; i < 3; i++) mem[16'h300 + i] = 16'h1;
        mem[16'h303] = 16'h8000;
        mem[16'h2fe] = 16'h7777;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, tsmu_pkg::OFS_ACC, 32'h0);
        chk_w(rd, tsmu_pkg::RST_ACC);
        apb(1'b0, tsmu_pkg::OFS_STATUS, 32'h0);
        chk_w(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk_w(rd, 32'h0);
        chk_f(err, 1'b1);
        search(1'b0, 16'h100, 8'd0, 32'h0, mem[16'h100], 1'b0);
        search(1'b0, 16'h100, 8'd10, 32'habcd_000a, mem[16'h105], 1'b0);
        search(1'b0, 16'h100, 8'd10, 32'h5a5a_0009, mem[16'h109], 1'b0);
        search(1'b0, 16'h200, 8'd255, 32'h0, 16'h7777, 1'b1);
        search(1'b1, 16'h300, 8'd8, 32'h0, 16'hffff, 1'b0);
        search(1'b1, 16'h300, 8'd8, 32'h0, 16'h7fff, 1'b0);
        repeat (12) begin
            b = 16'($random(seed)) & 16'h3ff;
            l = 8'($random(seed));
            k = 16'($random(seed)) % ({8'h0, l} + 16'h1);
            g = 1'($random(seed));
            val = g ? 16'($random(seed)) : mem[b + k];
            search(g, b, l, {16'($random(seed)), k}, val, 1'b0);
        end
        mem[16'h600] = 16'h0;
        for (int i = 0; i < 3; i++) move(i[0]);
        apb(1'b1, tsmu_pkg::OFS_CTRL, 32'h10);
        apb(1'b0, tsmu_pkg::OFS_STATUS, 32'h0);
        chk_f(rd[tsmu_pkg::STAT_PLIM], 1'b0);
        last_lim = 1'b0;
        for (int i = 0; i < 3; i++) move(i[0]);
        mem[16'h600] = 16'h9;
        move(1'b0);
        test_done();
    end
endmodule : table_search_and_move_unit_tb
